// ==== rtl/pgdc_top.sv ====
// Register bank and phase manager for gate drive and phase transition.
`timescale 1ns/10ps
module pgdc_top
   import pgdc_pkg::*;
#(
   parameter int LOAD_W = 16,
   parameter int DROP_DEG1_CYCLES = DROP_DEG1_CYC,
   parameter int DROP_DEG2_CYCLES = DROP_DEG2_CYC,
   parameter int DROP_DEG3_CYCLES = DROP_DEG3_CYC
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regReset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic chargeEnable,
   input wire logic battery_switch,
   input wire logic battery_overvoltage_enable,
   input wire logic overvoltageDetect,
   input wire logic quasiDualMode,
   input wire logic buckMode,
   input wire logic [LOAD_W-1:0] loadCurrentMa,
   output logic [2:0] high_side_strength_ph1,
   output logic [2:0] low_side_strength_ph1,
   output logic battery_overvoltage_protection,
   output logic overvoltageTrip,
   output logic dualPhase
);

   //-------------------------------------------------------------------
   // Elaboration checks
   //-------------------------------------------------------------------
   if (LOAD_W < 14 || LOAD_W > 31) begin : g_bad_load_w
      $error("pgdc_top: LOAD_W must hold 9000 mA and stay below 32");
   end
   if (DROP_DEG1_CYCLES < 1 || DROP_DEG1_CYCLES >= (1 << DEG_CNT_W) ||
       DROP_DEG2_CYCLES < 1 || DROP_DEG2_CYCLES >= (1 << DEG_CNT_W) ||
       DROP_DEG3_CYCLES < 1 || DROP_DEG3_CYCLES >= (1 << DEG_CNT_W)) begin : g_bad_drop
      $error("pgdc_top: drop deglitch counts out of counter range");
   end

   //-------------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------------
   function automatic logic [LOAD_W-1:0] add_level(input logic [2:0] code);
      return LOAD_W'(TH_BASE_MA + TH_STEP_MA * int'(code));
   endfunction

   function automatic logic [DEG_CNT_W-1:0] add_cycles(
      input logic [1:0] code);
      logic [DEG_CNT_W-1:0] c;
      c = DEG_CNT_W'(ADD_DEG0_CYC);
      case (code)
         2'h1: c = DEG_CNT_W'(ADD_DEG1_CYC);
         2'h2: c = DEG_CNT_W'(ADD_DEG2_CYC);
         2'h3: c = DEG_CNT_W'(ADD_DEG3_CYC);
         default: c = DEG_CNT_W'(ADD_DEG0_CYC);
      endcase
      return c;
   endfunction

   function automatic logic [DEG_CNT_W-1:0] drop_cycles(
      input logic [1:0] code);
      logic [DEG_CNT_W-1:0] c;
      c = DEG_CNT_W'(DROP_DEG0_CYC);
      case (code)
         2'h1: c = DEG_CNT_W'(DROP_DEG1_CYCLES);
         2'h2: c = DEG_CNT_W'(DROP_DEG2_CYCLES);
         2'h3: c = DEG_CNT_W'(DROP_DEG3_CYCLES);
         default: c = DEG_CNT_W'(DROP_DEG0_CYC);
      endcase
      return c;
   endfunction

   //-------------------------------------------------------------------
   // Register file
   //-------------------------------------------------------------------
   logic [7:0] gate_drive_phase1;
   logic [7:0] phase_transition_control;
   logic [7:0] next_gate_drive_phase1;
   logic [7:0] next_phase_transition_control;
   logic [7:0] next_regRdData;
   logic next_regRdValid;

   always_comb begin
      next_gate_drive_phase1 = gate_drive_phase1;
      next_phase_transition_control = phase_transition_control;
      next_regRdData = regRdData;
      next_regRdValid = 1'b0;
      if (regReset) begin
         next_gate_drive_phase1 = RST_GATE_DRIVE;
         next_phase_transition_control = RST_PHASE_CTRL;
      end else if (regWrEn) begin
         if (regAddr == ADDR_GATE_DRIVE) begin
            // The reserved bit is not writable so it always reads zero.
            next_gate_drive_phase1 = regWrData & GATE_WR_MASK;
         end else if (regAddr == ADDR_PHASE_CTRL) begin
            next_phase_transition_control = regWrData;
         end
      end
      if (regRdEn) begin
         next_regRdValid = 1'b1;
         if (regAddr == ADDR_GATE_DRIVE) begin
            next_regRdData = gate_drive_phase1;
         end else if (regAddr == ADDR_PHASE_CTRL) begin
            next_regRdData = phase_transition_control;
         end else begin
            next_regRdData = RD_UNMAPPED;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gate_drive_phase1 <= RST_GATE_DRIVE;
         phase_transition_control <= RST_PHASE_CTRL;
         regRdData <= RD_UNMAPPED;
         regRdValid <= 1'b0;
      end else begin
         gate_drive_phase1 <= next_gate_drive_phase1;
         phase_transition_control <= next_phase_transition_control;
         regRdData <= next_regRdData;
         regRdValid <= next_regRdValid;
      end
   end

   // The drive fields go straight from the register to the drivers.
   assign high_side_strength_ph1 = gate_drive_phase1[HS_MSB:HS_LSB];
   assign low_side_strength_ph1 = gate_drive_phase1[LS_MSB:LS_LSB];

   //-------------------------------------------------------------------
   // Battery overvoltage gating
   //-------------------------------------------------------------------
   logic next_ovpActive;
   logic next_overvoltageTrip;

   always_comb begin
      if (gate_drive_phase1[OV_EXT_BIT]) begin
         next_ovpActive = battery_overvoltage_enable;
      end else begin
         next_ovpActive = battery_overvoltage_enable && chargeEnable &&
            battery_switch;
      end
      // The trip uses the gate of the same cycle to avoid a stale window.
      next_overvoltageTrip = next_ovpActive && overvoltageDetect;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         battery_overvoltage_protection <= 1'b0;
         overvoltageTrip <= 1'b0;
      end else begin
         battery_overvoltage_protection <= next_ovpActive;
         overvoltageTrip <= next_overvoltageTrip;
      end
   end

   //-------------------------------------------------------------------
   // Phase manager
   //-------------------------------------------------------------------
   pgdc_phase_t phase;
   pgdc_phase_t next_phase;
   logic [DEG_CNT_W-1:0] degCount;
   logic [DEG_CNT_W-1:0] next_degCount;
   logic [2:0] thCode;
   logic forceSingle;
   logic [LOAD_W-1:0] addLevel;
   logic [LOAD_W-1:0] dropLevel;
   logic addCond;
   logic dropCond;
   logic [DEG_CNT_W-1:0] degTarget;

   assign thCode = phase_transition_control[TH_MSB:TH_LSB];
   assign forceSingle = phase_transition_control[FORCE_SINGLE_BIT];
   assign addLevel = add_level(thCode);
   assign dropLevel = addLevel - LOAD_W'(HYST_MA);
   assign addCond = loadCurrentMa > addLevel;
   assign dropCond = loadCurrentMa < dropLevel;

   always_comb begin
      next_phase = phase;
      next_degCount = '0;
      degTarget = '0;
      if (!quasiDualMode || !buckMode) begin
         // Outside quasi dual buck the settings have no say.
         next_phase = PGDC_SINGLE;
      end else if (forceSingle) begin
         next_phase = PGDC_SINGLE;
      end else if (thCode == TH_FORCE_DUAL) begin
         next_phase = PGDC_DUAL;
      end else begin
         // Automatic mode steered by the threshold field.
         case (phase)
            PGDC_SINGLE: begin
               degTarget = add_cycles(
                  phase_transition_control[ADD_MSB:ADD_LSB]);
               if (addCond) begin
                  // Any lapse drops the count back to zero.
                  next_degCount = degCount + 1'b1;
                  if (next_degCount >= degTarget) begin
                     next_phase = PGDC_DUAL;
                     next_degCount = '0;
                  end
               end
            end
            PGDC_DUAL: begin
               degTarget = drop_cycles(
                  phase_transition_control[DROP_MSB:DROP_LSB]);
               if (dropCond) begin
                  next_degCount = degCount + 1'b1;
                  if (next_degCount >= degTarget) begin
                     next_phase = PGDC_SINGLE;
                     next_degCount = '0;
                  end
               end
            end
            default: next_phase = PGDC_SINGLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase <= PGDC_SINGLE;
         degCount <= '0;
      end else begin
         phase <= next_phase;
         degCount <= next_degCount;
      end
   end

   assign dualPhase = (phase == PGDC_DUAL);

endmodule

// ==== shared/pgdc_pkg.sv ====
// Constants, register map and timing for the phase and gate drive config.
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
package pgdc_pkg;
   localparam int CLK_FREQ_HZ = 10_000_000;
   // Register offsets.
   localparam logic [7:0] ADDR_GATE_DRIVE = 8'h13;
   localparam logic [7:0] ADDR_PHASE_CTRL = 8'h14;
   // Reset values.
   localparam logic [7:0] RST_GATE_DRIVE = 8'h6c;
   localparam logic [7:0] RST_PHASE_CTRL = 8'h85;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // Gate drive field layout; bit 1 is reserved and reads zero.
   localparam int HS_MSB = 7;
   localparam int HS_LSB = 5;
   localparam int LS_MSB = 4;
   localparam int LS_LSB = 2;
   localparam int OV_EXT_BIT = 0;
   localparam logic [7:0] GATE_WR_MASK = 8'hfd;
   // Phase control field layout.
   localparam int TH_MSB = 7;
   localparam int TH_LSB = 5;
   localparam int FORCE_SINGLE_BIT = 4;
   localparam int ADD_MSB = 3;
   localparam int ADD_LSB = 2;
   localparam int DROP_MSB = 1;
   localparam int DROP_LSB = 0;
   localparam logic [2:0] TH_FORCE_DUAL = 3'h0;
   // Threshold in mA: code 1 is 3A, 1A per step, drop is 1A lower.
   localparam int TH_BASE_MA = 2000;
   localparam int TH_STEP_MA = 1000;
   localparam int HYST_MA = 1000;
   // Deglitch times in ns, typical values.
   localparam longint ADD_DEG0_NS = 1700;
   localparam longint ADD_DEG1_NS = 5500;
   localparam longint ADD_DEG2_NS = 20000;
   localparam longint ADD_DEG3_NS = 86000;
   localparam longint DROP_DEG0_NS = 93000;
   localparam longint DROP_DEG1_NS = 1500000;
   localparam longint DROP_DEG2_NS = 11000000;
   localparam longint DROP_DEG3_NS = 94000000;
   // Least times round up to whole cycles.
   function automatic int ns_to_cyc(input longint ns);
      return int'((ns * CLK_FREQ_HZ + 64'd999_999_999) / 64'd1_000_000_000);
   endfunction
   localparam int ADD_DEG0_CYC = ns_to_cyc(ADD_DEG0_NS);
   localparam int ADD_DEG1_CYC = ns_to_cyc(ADD_DEG1_NS);
   localparam int ADD_DEG2_CYC = ns_to_cyc(ADD_DEG2_NS);
   localparam int ADD_DEG3_CYC = ns_to_cyc(ADD_DEG3_NS);
   localparam int DROP_DEG0_CYC = ns_to_cyc(DROP_DEG0_NS);
   localparam int DROP_DEG1_CYC = ns_to_cyc(DROP_DEG1_NS);
   localparam int DROP_DEG2_CYC = ns_to_cyc(DROP_DEG2_NS);
   localparam int DROP_DEG3_CYC = ns_to_cyc(DROP_DEG3_NS);
   localparam int DEG_CNT_W = 20;
   typedef enum logic {PGDC_SINGLE, PGDC_DUAL} pgdc_phase_t;
endpackage

// ==== testbench/pgdc_checker_sva.sv ====
// Concurrent checks on the ports of the phase and gate drive config.
`timescale 1ns/10ps
module pgdc_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regReset,
   input wire logic [7:0] regAddr,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic chargeEnable,
   input wire logic battery_switch,
   input wire logic battery_overvoltage_enable,
   input wire logic overvoltageDetect,
   input wire logic quasiDualMode,
   input wire logic buckMode,
   input wire logic [2:0] high_side_strength_ph1,
   input wire logic [2:0] low_side_strength_ph1,
   input wire logic battery_overvoltage_protection,
   input wire logic overvoltageTrip,
   input wire logic dualPhase
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rd_answer;
      regRdEn |=> regRdValid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read strobe got no valid pulse");
   property p_rd_quiet;
      !regRdEn |=> !regRdValid;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("valid pulse without a read");
   property p_unmapped;
      regRdEn && regAddr != 8'h13 && regAddr != 8'h14 |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");
   property p_strength_reset;
      regReset |=> high_side_strength_ph1 == 3'h3 &&
         low_side_strength_ph1 == 3'h3;
   endproperty
   a_strength_reset: assert property (p_strength_reset)
      else $error("strengths not back to code 3");
   property p_ovp_off;
      !battery_overvoltage_enable |=> !battery_overvoltage_protection;
   endproperty
   a_ovp_off: assert property (p_ovp_off)
      else $error("protection active while disabled");
   property p_ovp_charging;
      chargeEnable && battery_switch && battery_overvoltage_enable
         |=> battery_overvoltage_protection;
   endproperty
   a_ovp_charging: assert property (p_ovp_charging)
      else $error("protection off while charging");
   property p_trip_follow;
      chargeEnable && battery_switch && battery_overvoltage_enable &&
         overvoltageDetect |=> overvoltageTrip;
   endproperty
   a_trip_follow: assert property (p_trip_follow)
      else $error("trip missed while charging");
   property p_trip_off;
      !battery_overvoltage_enable |=> !overvoltageTrip;
   endproperty
   a_trip_off: assert property (p_trip_off)
      else $error("trip while protection disabled");
   property p_not_quasi;
      !quasiDualMode |=> !dualPhase;
   endproperty
   a_not_quasi: assert property (p_not_quasi)
      else $error("dual phase outside quasi dual mode");
   property p_not_buck;
      !buckMode |=> !dualPhase;
   endproperty
   a_not_buck: assert property (p_not_buck)
      else $error("dual phase outside buck mode");
endmodule
bind pgdc_top pgdc_checker pgdc_checker_i (.clk(clk), .sys_rst(sys_rst),
   .regReset(regReset), .regAddr(regAddr), .regRdEn(regRdEn),
   .regRdData(regRdData), .regRdValid(regRdValid),
   .chargeEnable(chargeEnable), .battery_switch(battery_switch),
   .battery_overvoltage_enable(battery_overvoltage_enable),
   .quasiDualMode(quasiDualMode), .buckMode(buckMode),
   .high_side_strength_ph1(high_side_strength_ph1),
   .low_side_strength_ph1(low_side_strength_ph1),
   .battery_overvoltage_protection(battery_overvoltage_protection),
   .overvoltageDetect(overvoltageDetect),
   .overvoltageTrip(overvoltageTrip),
   .dualPhase(dualPhase));

// ==== testbench/pgdc_host_model.sv ====
// Host side model issuing decoded register writes and reads.
`timescale 1ns/10ps
module pgdc_host_model (
   input wire logic clk,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // Idle lines are scrambled so a stale address never looks valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdValid === 1'b1 ? regRdData : 8'hxx;
   endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking testbench for the phase and gate drive config.
`timescale 1ns/10ps
module tb;
   import pgdc_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, regReset = 1'b0, regWrEn, regRdEn;
   logic [7:0] regAddr, regWrData, regRdData, d;
   logic regRdValid, chargeEnable = 1'b0, battery_switch = 1'b0;
   logic battery_overvoltage_enable = 1'b1, overvoltageDetect = 1'b0;
   logic quasiDualMode = 1'b0, buckMode = 1'b0;
   logic [15:0] loadCurrentMa = 16'h0000;
   logic [2:0] hs, ls;
   logic prot, trip, dualPhase;
   int nMismatch = 0, totalChecks = 0;
   // Short drop counts keep the run small; the ratios still differ.
   localparam int TB_DROP1 = 40;
   localparam int TB_DROP3 = 80;
   always #50 clk = ~clk;
   pgdc_top #(.DROP_DEG1_CYCLES(TB_DROP1), .DROP_DEG2_CYCLES(60),
      .DROP_DEG3_CYCLES(TB_DROP3)) pgdc_top_i (.clk(clk), .sys_rst(sys_rst),
      .regReset(regReset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid), .chargeEnable(chargeEnable),
      .battery_switch(battery_switch),
      .battery_overvoltage_enable(battery_overvoltage_enable),
      .overvoltageDetect(overvoltageDetect), .quasiDualMode(quasiDualMode),
      .buckMode(buckMode), .loadCurrentMa(loadCurrentMa),
      .high_side_strength_ph1(hs), .low_side_strength_ph1(ls),
      .battery_overvoltage_protection(prot), .overvoltageTrip(trip),
      .dualPhase(dualPhase));
   pgdc_host_model host_i (.clk(clk), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .regRdValid(regRdValid));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         nMismatch++;
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic complete_run;
      if (nMismatch == 0 && totalChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic t_regs;
      host_i.rd(8'h13, d);
      chk(d, 8'h6c);
      host_i.rd(8'h14, d);
      chk(d, 8'h85);
      for (int i = 0; i < 8; i++) begin
         host_i.wr(8'h13, {i[2:0], i[2:0], 2'h0});
         chk({2'h0, hs, ls}, {2'h0, i[2:0], i[2:0]});
      end
      host_i.wr(8'h13, 8'hff);
      host_i.rd(8'h13, d);
      chk(d, 8'hfd);
      host_i.rd(8'h15, d);
      chk(d, 8'h00);
   endtask
   task automatic t_ovp;
      host_i.wr(8'h13, 8'h00);
      wt(2);
      chk({prot, trip}, 2'h0);
      chargeEnable = 1'b1;
      battery_switch = 1'b1;
      overvoltageDetect = 1'b1;
      wt(3);
      chk({prot, trip}, 2'h3);
      battery_switch = 1'b0;
      wt(2);
      chk({prot, trip}, 2'h0);
      chargeEnable = 1'b0;
      battery_switch = 1'b1;
      wt(2);
      chk({prot, trip}, 2'h0);
      host_i.wr(8'h13, 8'h01);
      battery_switch = 1'b0;
      wt(2);
      chk({prot, trip}, 2'h3);
      battery_overvoltage_enable = 1'b0;
      wt(2);
      chk({prot, trip}, 2'h0);
   endtask
   task automatic t_phase;
      quasiDualMode = 1'b1;
      buckMode = 1'b1;
      host_i.wr(8'h14, 8'h81);
      loadCurrentMa = 16'd6000;
      wt(30);
      chk(dualPhase, 1'b0);
      loadCurrentMa = 16'd7000;
      wt(10);
      loadCurrentMa = 16'd5000;
      wt(1);
      loadCurrentMa = 16'd7000;
      wt(ADD_DEG0_CYC - 1);
      chk(dualPhase, 1'b0);
      wt(1);
      chk(dualPhase, 1'b1);
      loadCurrentMa = 16'd5000;
      wt(60);
      chk(dualPhase, 1'b1);
      loadCurrentMa = 16'd4999;
      wt(TB_DROP1 - 1);
      chk(dualPhase, 1'b1);
      wt(1);
      chk(dualPhase, 1'b0);
      host_i.wr(8'h14, 8'h91);
      loadCurrentMa = 16'd9000;
      wt(30);
      chk(dualPhase, 1'b0);
      host_i.wr(8'h14, 8'h01);
      loadCurrentMa = 16'd0;
      wt(2);
      chk(dualPhase, 1'b1);
      quasiDualMode = 1'b0;
      wt(2);
      chk(dualPhase, 1'b0);
      quasiDualMode = 1'b1;
      wt(2);
      chk(dualPhase, 1'b1);
      buckMode = 1'b0;
      wt(2);
      chk(dualPhase, 1'b0);
   endtask
   // Highest threshold with the slowest add and drop codes.
   task automatic t_phase_codes;
      host_i.wr(8'h14, 8'hef);
      host_i.rd(8'h14, d);
      chk(d, 8'hef);
      buckMode = 1'b1;
      loadCurrentMa = 16'd9000;
      wt(ADD_DEG3_CYC + 10);
      chk(dualPhase, 1'b0);
      loadCurrentMa = 16'd9001;
      wt(ADD_DEG3_CYC - 1);
      chk(dualPhase, 1'b0);
      wt(1);
      chk(dualPhase, 1'b1);
      loadCurrentMa = 16'd8000;
      wt(100);
      chk(dualPhase, 1'b1);
      loadCurrentMa = 16'd7999;
      wt(TB_DROP3 - 1);
      chk(dualPhase, 1'b1);
      wt(1);
      chk(dualPhase, 1'b0);
   endtask
   task automatic t_regreset;
      regReset = 1'b1;
      wt(1);
      regReset = 1'b0;
      chk({2'h0, hs, ls}, 8'h1b);
      host_i.rd(8'h14, d);
      chk(d, 8'h85);
      host_i.rd(8'h13, d);
      chk(d, 8'h6c);
   endtask
   initial begin
      wt(20);
      sys_rst = 1'b0;
      t_regs();
      t_ovp();
      t_phase();
      t_phase_codes();
      t_regreset();
      complete_run();
   end
   // The sequence needs about 2200 cycles; some four and a half times that means a hang.
   initial begin
      #(10000 * 100);
      nMismatch++;
      complete_run();
   end
endmodule
